// file: design/colour_regs_pkg.sv
package colour_regs_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_WAIT_EXTEND_CONFIG = 8'h0d;
  localparam logic [7:0] ADDR_GAIN_CONTROL = 8'h0f;
  localparam logic [7:0] ADDR_PART_IDENTIFICATION = 8'h12;
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h13;
  localparam logic [7:0] ADDR_CHAN_FIRST = 8'h14;
  localparam logic [7:0] ADDR_CHAN_LAST = 8'h1b;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int WAIT_EXTEND_POS = 1;
  localparam int IRQ_FLAG_POS = 4;
  localparam int VALID_FLAG_POS = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_GAIN = 2'h0;

  // ----------------------------------------
  // Gain encodings and factors
  // ----------------------------------------
  localparam logic [1:0] GAIN_SEL_1X = 2'h0;
  localparam logic [1:0] GAIN_SEL_4X = 2'h1;
  localparam logic [1:0] GAIN_SEL_16X = 2'h2;
  localparam logic [1:0] GAIN_SEL_60X = 2'h3;
  localparam logic [6:0] GAIN_FACTOR_1X = 7'h01;
  localparam logic [6:0] GAIN_FACTOR_4X = 7'h04;
  localparam logic [6:0] GAIN_FACTOR_16X = 7'h10;
  localparam logic [6:0] GAIN_FACTOR_60X = 7'h3c;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned WAIT_STEP_US = 2400;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
  localparam logic [3:0] WAIT_EXTEND_FACTOR = 4'hc;
  localparam logic [8:0] WAIT_STEP_SPAN = 9'h100;

  // ----------------------------------------
  // Persistence
  // ----------------------------------------
  localparam logic [3:0] PERS_LINEAR_LAST = 4'h3;
  localparam logic [5:0] PERS_STRIDE = 6'h05;
endpackage

// file: design/colour_regs.sv
// Summary of operation
// - Extend bit stretches each wait twelvefold
// - Two-bit gain selects 1, 4, 16, 60
// - Fixed read-only part code at 0x12
// - Status at 0x13 ignores host writes
// - Interrupt in bit 4, reserved read zero
// - Valid bit set after integration completes
// - Four 16-bit results at 0x14-0x1b
// - Low read latches high byte into shadow
// - High byte matches low despite updates
// - Wait step 2.4 ms, two's-complement count
// - Clear out of thresholds raises interrupt
`timescale 1ns/100ps
module colour_regs #(
  parameter int unsigned WAIT_STEP_CYCLES = colour_regs_pkg::WAIT_STEP_CYCLES,
  parameter logic [7:0] PART_CODE = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register byte port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Measurement engine
  input wire logic colour_enable_in,
  input wire logic integ_done_in,
  input wire logic [15:0] clear_data_in,
  input wire logic [15:0] red_data_in,
  input wire logic [15:0] green_data_in,
  input wire logic [15:0] blue_data_in,
  // Threshold settings
  input wire logic [15:0] low_threshold_in,
  input wire logic [15:0] high_threshold_in,
  input wire logic [3:0] persistence_in,
  input wire logic irq_clear_in,
  // Wait timer
  input wire logic wait_start_in,
  input wire logic [7:0] wait_step_count_in,
  output logic wait_active_out,
  output logic wait_done_out,
  // Analog controls and flags
  output logic wait_extend_bit_out,
  output logic [1:0] analog_gain_select_out,
  output logic [6:0] gain_factor_out,
  output logic clear_threshold_irq_flag_out,
  output logic measurement_valid_flag_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Gain code to multiplier
  function automatic logic [6:0] gain_factor(input logic [1:0] sel);
    logic [6:0] f;
    f = colour_regs_pkg::GAIN_FACTOR_1X;
    unique case (sel)
      colour_regs_pkg::GAIN_SEL_1X: f = colour_regs_pkg::GAIN_FACTOR_1X;
      colour_regs_pkg::GAIN_SEL_4X: f = colour_regs_pkg::GAIN_FACTOR_4X;
      colour_regs_pkg::GAIN_SEL_16X: f = colour_regs_pkg::GAIN_FACTOR_16X;
      colour_regs_pkg::GAIN_SEL_60X: f = colour_regs_pkg::GAIN_FACTOR_60X;
    endcase
    return f;
  endfunction

  // Persistence code to consecutive count, zero means every result
  function automatic logic [5:0] pers_need(input logic [3:0] p);
    logic [5:0] n;
    n = {2'h0, p};
    if (p > colour_regs_pkg::PERS_LINEAR_LAST) begin
      n = 6'((p - colour_regs_pkg::PERS_LINEAR_LAST) * colour_regs_pkg::PERS_STRIDE);
    end
    return n;
  endfunction

  // Byte write hit on one address
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr_in && (reg_addr_in == a);
  endfunction

  // ----------------------------------------
  // Configuration and gain
  // ----------------------------------------
  logic wait_extend_r, wait_extend_nxt; // Stretch bit
  logic [1:0] gain_r, gain_nxt; // Gain select
  logic [6:0] gain_factor_r, gain_factor_nxt; // Decoded multiplier

  // Only meaningful bits stored
  always_comb begin
    wait_extend_nxt = wait_extend_r;
    gain_nxt = gain_r;
    if (wr_hit(colour_regs_pkg::ADDR_WAIT_EXTEND_CONFIG)) begin
      wait_extend_nxt = reg_wdata_in[colour_regs_pkg::WAIT_EXTEND_POS];
    end
    if (wr_hit(colour_regs_pkg::ADDR_GAIN_CONTROL)) begin
      gain_nxt = reg_wdata_in[1:0];
    end
    gain_factor_nxt = gain_factor(gain_nxt);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_extend_r <= 1'b0;
      gain_r <= colour_regs_pkg::RESET_GAIN;
      gain_factor_r <= colour_regs_pkg::GAIN_FACTOR_1X;
    end else begin
      wait_extend_r <= wait_extend_nxt;
      gain_r <= gain_nxt;
      gain_factor_r <= gain_factor_nxt;
    end
  end

  // ----------------------------------------
  // Wait timer
  // ----------------------------------------
  logic wait_active_r, wait_active_nxt; // Timer running
  logic wait_done_r, wait_done_nxt; // End pulse
  logic [31:0] cyc_r, cyc_nxt; // Cycles within a step slice
  logic [3:0] slice_r, slice_nxt; // Slices within a step
  logic [8:0] steps_r, steps_nxt; // Steps left
  logic extend_lat_r, extend_lat_nxt; // Extend bit frozen at start

  // Nested counters; extend bit sampled at start so a late write
  // cannot leave the wait half stretched
  always_comb begin
    wait_active_nxt = wait_active_r;
    wait_done_nxt = 1'b0;
    cyc_nxt = cyc_r;
    slice_nxt = slice_r;
    steps_nxt = steps_r;
    extend_lat_nxt = extend_lat_r;
    if (!wait_active_r) begin
      if (wait_start_in) begin
        wait_active_nxt = 1'b1;
        steps_nxt = colour_regs_pkg::WAIT_STEP_SPAN - {1'b0, wait_step_count_in};
        cyc_nxt = 32'h0;
        slice_nxt = 4'h0;
        extend_lat_nxt = wait_extend_r;
      end
    end else if (cyc_r == WAIT_STEP_CYCLES - 1) begin
      cyc_nxt = 32'h0;
      if (extend_lat_r && (slice_r != colour_regs_pkg::WAIT_EXTEND_FACTOR - 4'h1)) begin
        slice_nxt = slice_r + 4'h1;
      end else begin
        slice_nxt = 4'h0;
        steps_nxt = steps_r - 9'h1;
        if (steps_r == 9'h1) begin
          wait_active_nxt = 1'b0;
          wait_done_nxt = 1'b1;
        end
      end
    end else begin
      cyc_nxt = cyc_r + 32'h1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_active_r <= 1'b0;
      wait_done_r <= 1'b0;
      cyc_r <= 32'h0;
      slice_r <= 4'h0;
      steps_r <= 9'h0;
      extend_lat_r <= 1'b0;
    end else begin
      wait_active_r <= wait_active_nxt;
      wait_done_r <= wait_done_nxt;
      cyc_r <= cyc_nxt;
      slice_r <= slice_nxt;
      steps_r <= steps_nxt;
      extend_lat_r <= extend_lat_nxt;
    end
  end

  // ----------------------------------------
  // Results, status and interrupt
  // ----------------------------------------
  logic [15:0] chan_r [4]; // Clear, red, green, blue
  logic [15:0] chan_nxt [4];
  logic valid_r, valid_nxt; // Measurement valid
  logic irq_r, irq_nxt; // Clear threshold interrupt
  logic [5:0] pers_cnt_r, pers_cnt_nxt; // Consecutive out-of-range count
  logic out_of_range; // Clear result outside window
  logic [5:0] need; // Required consecutive count

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chan_nxt[i] = chan_r[i];
    end
    valid_nxt = valid_r;
    irq_nxt = irq_r;
    pers_cnt_nxt = pers_cnt_r;
    need = pers_need(persistence_in);
    out_of_range = (clear_data_in < low_threshold_in) || (clear_data_in > high_threshold_in);
    // flags move only on hardware events
    // Clears first so a same-cycle event wins
    if (!colour_enable_in) begin
      valid_nxt = 1'b0;
    end
    if (irq_clear_in) begin
      irq_nxt = 1'b0;
    end
    if (integ_done_in) begin
      chan_nxt[0] = clear_data_in;
      chan_nxt[1] = red_data_in;
      chan_nxt[2] = green_data_in;
      chan_nxt[3] = blue_data_in;
      valid_nxt = 1'b1;
      if (need == 6'h0) begin
        irq_nxt = 1'b1;
      end else if (out_of_range) begin
        if (pers_cnt_r != 6'h3f) begin
          pers_cnt_nxt = pers_cnt_r + 6'h1;
        end
        // Widened so a saturated count cannot wrap to zero
        if (({1'b0, pers_cnt_r} + 7'h1) >= {1'b0, need}) begin
          irq_nxt = 1'b1;
        end
      end else begin
        pers_cnt_nxt = 6'h0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 4; i++) begin
        chan_r[i] <= 16'h0;
      end
      valid_r <= 1'b0;
      irq_r <= 1'b0;
      pers_cnt_r <= 6'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        chan_r[i] <= chan_nxt[i];
      end
      valid_r <= valid_nxt;
      irq_r <= irq_nxt;
      pers_cnt_r <= pers_cnt_nxt;
    end
  end

  // ----------------------------------------
  // Read port and shadow byte
  // ----------------------------------------
  logic [7:0] rdata_r, rdata_nxt; // Read byte
  logic rvalid_r, rvalid_nxt; // Read answer strobe
  logic [7:0] shadow_r, shadow_nxt; // Latched upper byte
  logic chan_hit; // Address in result window
  logic [1:0] chan_idx; // Channel selected

  // Shared shadow: only one word may be in flight at a time
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd_in;
    shadow_nxt = shadow_r;
    chan_hit = (reg_addr_in >= colour_regs_pkg::ADDR_CHAN_FIRST) && (reg_addr_in <= colour_regs_pkg::ADDR_CHAN_LAST);
    chan_idx = 2'((reg_addr_in - colour_regs_pkg::ADDR_CHAN_FIRST) >> 1);
    if (reg_rd_in) begin
      rdata_nxt = colour_regs_pkg::RESET_BYTE;
      if (chan_hit) begin
        if (!reg_addr_in[0]) begin
          rdata_nxt = chan_r[chan_idx][7:0];
          shadow_nxt = chan_r[chan_idx][15:8];
        end else begin
          rdata_nxt = shadow_r;
        end
      end else if (reg_addr_in == colour_regs_pkg::ADDR_WAIT_EXTEND_CONFIG) begin
        rdata_nxt[colour_regs_pkg::WAIT_EXTEND_POS] = wait_extend_r;
      end else if (reg_addr_in == colour_regs_pkg::ADDR_GAIN_CONTROL) begin
        rdata_nxt[1:0] = gain_r;
      end else if (reg_addr_in == colour_regs_pkg::ADDR_PART_IDENTIFICATION) begin
        rdata_nxt = PART_CODE;
      end else if (reg_addr_in == colour_regs_pkg::ADDR_DEVICE_STATUS) begin
        rdata_nxt[colour_regs_pkg::IRQ_FLAG_POS] = irq_r;
        rdata_nxt[colour_regs_pkg::VALID_FLAG_POS] = valid_r;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r <= colour_regs_pkg::RESET_BYTE;
      rvalid_r <= 1'b0;
      shadow_r <= colour_regs_pkg::RESET_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      shadow_r <= shadow_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign wait_active_out = wait_active_r;
  assign wait_done_out = wait_done_r;
  assign wait_extend_bit_out = wait_extend_r;
  assign analog_gain_select_out = gain_r;
  assign gain_factor_out = gain_factor_r;
  assign clear_threshold_irq_flag_out = irq_r;
  assign measurement_valid_flag_out = valid_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] wait_elapsed_r; // Cycles since wait start
  logic [31:0] wait_expect_r; // Expected wait length
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_elapsed_r <= 32'h0;
      wait_expect_r <= 32'h0;
    end else if (!wait_active_r && wait_start_in) begin
      wait_elapsed_r <= 32'h0;
      wait_expect_r <= 32'((colour_regs_pkg::WAIT_STEP_SPAN - {1'b0, wait_step_count_in}) * WAIT_STEP_CYCLES
                       * (wait_extend_r ? 32'd12 : 32'd1));
    end else if (wait_active_r) begin
      wait_elapsed_r <= wait_elapsed_r + 32'h1;
    end
  end

  a_wait_length: assert property (@(posedge clk_in) disable iff (!nrst_in)
    wait_done_r |-> (wait_elapsed_r == wait_expect_r)) else $error("Wait length wrong");
  a_gain_map: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $changed(gain_r) |-> ((gain_r == 2'h3) == (gain_factor_r == 7'h3c)) && ((gain_r == 2'h0) == (gain_factor_r == 7'h01)))
    else $error("Gain factor mismatch");
  a_id_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == 8'h12) |=> (reg_rvalid_out && reg_rdata_out == PART_CODE)) else $error("Bad part code");
  a_status_ro: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == colour_regs_pkg::ADDR_DEVICE_STATUS && !integ_done_in && colour_enable_in
      && !irq_clear_in) |=> ($stable(valid_r) && $stable(irq_r)))
    else $error("Status changed by write");
  a_status_layout: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == 8'h13) |=> (reg_rdata_out[7:5] == 3'h0 && reg_rdata_out[3:1] == 3'h0
      && reg_rdata_out[4] == $past(irq_r) && reg_rdata_out[0] == $past(valid_r))) else $error("Status layout wrong");
  a_valid_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
    integ_done_in |=> valid_r) else $error("Valid not set");
  a_shadow_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == 8'h14) |=> (shadow_r == $past(chan_r[0][15:8]) && reg_rdata_out == $past(chan_r[0][7:0])))
    else $error("Shadow not latched");
  a_high_coherent: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == 8'h1b) |=> (reg_rdata_out == $past(shadow_r))) else $error("High byte incoherent");
  a_irq_raise: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (integ_done_in && persistence_in == 4'h1 && clear_data_in < low_threshold_in) |=> irq_r)
    else $error("Interrupt not raised");

endmodule

// file: verification/host_model.sv
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clk_in,
  // Register byte port
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  // Idle bus at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end

  // --------------------------------
  // Byte cycles
  // --------------------------------
  // caller picks reserved bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    // Released lines flip so stale values never look valid
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask

  // Read strobe, answer bounded to a few edges
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    do begin
      @(posedge clk_in);
      n++;
    end while (reg_rvalid_in !== 1'b1 && n < 4);
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hxx;
  endtask

  task automatic rd_word(input logic [7:0] a, output logic [15:0] w);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    w = {hi, lo};
  endtask
endmodule

// file: verification/color_sensor_config_status_data_regs_test.sv
`timescale 1ns/100ps
module color_sensor_config_status_data_regs_test;
  // --------------------------------
  // Signals
  // --------------------------------
  localparam int unsigned STEP = 4; // Shortened wait step
  localparam logic [7:0] CODE = 8'hc3; // Arbitrary part code
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rvalid, wact, wdone, wext, irq, valid;
  logic [1:0] gsel;
  logic [6:0] gfac;
  logic en = 1'b1;
  logic idone = 1'b0;
  logic [15:0] dat [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] lo_th = 16'h0100;
  logic [15:0] hi_th = 16'h8000;
  logic [3:0] pers = 4'h0;
  logic iclr = 1'b0;
  logic wstart = 1'b0;
  logic [7:0] wcnt = 8'h00;
  int n_errors = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  colour_regs #(.WAIT_STEP_CYCLES(STEP), .PART_CODE(CODE)) i_colour_regs (
    .clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .colour_enable_in(en),
    .integ_done_in(idone), .clear_data_in(dat[0]), .red_data_in(dat[1]), .green_data_in(dat[2]),
    .blue_data_in(dat[3]), .low_threshold_in(lo_th), .high_threshold_in(hi_th), .persistence_in(pers),
    .irq_clear_in(iclr), .wait_start_in(wstart), .wait_step_count_in(wcnt), .wait_active_out(wact),
    .wait_done_out(wdone), .wait_extend_bit_out(wext), .analog_gain_select_out(gsel),
    .gain_factor_out(gfac), .clear_threshold_irq_flag_out(irq), .measurement_valid_flag_out(valid));

  host_model i_host_model (.clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
    .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_model.rd(a, d);
    check(what, d, exp);
  endtask

  // One result strobe; data lines flip afterwards
  task automatic integ(input logic [15:0] c);
    @(posedge clk);
    idone <= 1'b1;
    for (int i = 0; i < 4; i++) dat[i] <= 16'(c + 16'h1111 * i);
    @(posedge clk);
    idone <= 1'b0;
    for (int i = 0; i < 4; i++) dat[i] <= 16'(~(c + 16'h1111 * i));
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_config();
    logic [6:0] fac [4] = '{7'h01, 7'h04, 7'h10, 7'h3c};
    check("gain reset", gfac, 7'h01);
    i_host_model.wr(8'h0d, 8'hff);
    rd_chk("config", 8'h0d, 8'h02);
    check("extend out", wext, 1'b1);
    i_host_model.wr(8'h0d, 8'h00);
    for (int g = 0; g < 4; g++) begin
      i_host_model.wr(8'h0f, 8'hfc | g[7:0]);
      rd_chk("gain", 8'h0f, g[7:0]);
      check("gain sel", gsel, g[1:0]);
      check("gain fac", gfac, fac[g]);
    end
  endtask

  task automatic t_ident_status();
    rd_chk("id", 8'h12, CODE);
    i_host_model.wr(8'h12, ~CODE);
    rd_chk("id after wr", 8'h12, CODE);
    i_host_model.wr(8'h13, 8'hff);
    rd_chk("status wr", 8'h13, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
  endtask

  task automatic t_measure();
    integ(16'h1000);
    rd_chk("status every", 8'h13, 8'h11);
    check("valid out", valid, 1'b1);
    // Writing zeros must not clear raised flags
    i_host_model.wr(8'h13, 8'h00);
    rd_chk("status wr0", 8'h13, 8'h11);
    @(posedge clk) iclr <= 1'b1;
    @(posedge clk) iclr <= 1'b0;
    rd_chk("status cleared", 8'h13, 8'h01);
    pers <= 4'h2;
    integ(16'h0050);
    integ(16'h1000);
    integ(16'h9000);
    rd_chk("status broken run", 8'h13, 8'h01);
    integ(16'h0020);
    @(posedge clk);
    check("irq out", irq, 1'b1);
    @(posedge clk) en <= 1'b0;
    @(posedge clk) en <= 1'b1;
    @(posedge clk);
    check("valid off", valid, 1'b0);
    // one out-of-range result, set beats same-cycle clear
    pers <= 4'h1;
    @(posedge clk) iclr <= 1'b1;
    @(posedge clk) iclr <= 1'b0;
    @(posedge clk);
    check("irq cleared", irq, 1'b0);
    iclr <= 1'b1;
    integ(16'h0020);
    iclr <= 1'b0;
    @(posedge clk);
    check("irq set wins", irq, 1'b1);
  endtask

  task automatic t_shadow();
    logic [15:0] w;
    logic [15:0] v;
    integ(16'h1234);
    for (int i = 0; i < 4; i++) begin
      v = 16'(16'h1234 + 16'h1111 * i);
      i_host_model.rd_word(8'h14 + 8'(2 * i), w);
      check("word", w, v);
      // new result between low and high
      rd_chk("low", 8'h14 + 8'(2 * i), v[7:0]);
      integ(~v);
      rd_chk("high", 8'h15 + 8'(2 * i), v[15:8]);
      integ(16'h1234);
    end
  endtask

  task automatic t_wait(input logic [7:0] cnt, input logic ext, input int unsigned exp);
    int n;
    n = 0;
    i_host_model.wr(8'h0d, {6'h00, ext, 1'b0});
    @(posedge clk);
    wstart <= 1'b1;
    wcnt <= cnt;
    @(posedge clk);
    wstart <= 1'b0;
    wcnt <= ~cnt;
    @(posedge clk);
    n = 1;
    check("wait active", wact, 1'b1);
    while (wdone !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("wait cycles", 16'(n), 16'(exp + 1));
  endtask

  // --------------------------------
  // Run
  // --------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_config();
    t_ident_status();
    t_measure();
    t_shadow();
    t_wait(8'hfe, 1'b0, 2 * STEP);
    t_wait(8'hff, 1'b1, 12 * STEP);
    tally_and_finish();
  end

  // Watchdog well past the few hundred edges needed
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
